// [pkg/etp_pkg.sv]
// constants, types and helpers for the exception trace packet encoder
// assumes a single clock domain; every user imports nothing and writes etp_pkg::name
// Contract
// (R1) each packet starts with header byte, then indicator byte split around type
// (R2) word-aligned set: return address bits 1:0 forced zero, never sent
// (R3) halfword-aligned set: return address bit 0 forced zero, never sent
// (R4) return address compressed against address history entry zero
// (R5) sent bits overwrite matching reference bits; unsent bits keep reference
// (R6) no context: indicator 01 exception alone, 10 target then exception
// (R7) only defined indicator values are ever emitted
// (R8) exception type is a five-bit code from the defined table
// (R9) type 11000 is never used here; other undefined codes refused too
// (R10) 64-bit word form: bytes A[8:2], A[15:9] with bit7 zero, six more bytes
// (R11) 64-bit halfword form: A[7:1] bit7 zero, A[15:8], six more bytes
// (R12) 32-bit word context form: four address bytes then context byte
// (R13) 32-bit halfword context form: A[7:1] first, then same context byte
// (R14) context byte top bits flag tags; virtual tag first, each LSB first
// (R15) context forms: indicator 01 context+exception, 10 target+context+exception
// (R16) omitted context tag equals last one sent; device tracks that value
// (R17) context tag tracing off: field omitted
// (R18) omitted virtual tag equals last one sent; device tracks that value
// (R19) virtual tag tracing off: field omitted
// (R20) privilege level is a plain two-bit binary field
// (R21) nonsecure flag 0 secure, 1 nonsecure
// (R22) wide state flag 0 for 32-bit state, 1 for 64-bit state
// (R23) packet bytes leave strictly in order, no interleaving

`default_nettype none

package etp_pkg;

	// ************************************************************
	// byte codes
	// ************************************************************
	localparam logic [7:0] HDR_BYTE = 8'h06;
	localparam logic [7:0] FMT_64_WORD = 8'h9D;
	localparam logic [7:0] FMT_64_HALF = 8'h9E;
	localparam logic [7:0] FMT_32C_WORD = 8'h82;
	localparam logic [7:0] FMT_32C_HALF = 8'h83;
	localparam logic [1:0] IND_EXC_ONLY = 2'h1;
	localparam logic [1:0] IND_TGT_EXC = 2'h2;
	localparam logic [4:0] TYPE_TXN_FAIL = 5'h18;

	// ************************************************************
	// positions, lengths, reset values
	// ************************************************************
	localparam int PKT_MAX = 16;
	localparam logic [4:0] LEN_64 = 5'h0B;
	localparam logic [4:0] LEN_CTX_BASE = 5'h08;
	localparam logic [4:0] LEN_TAG = 5'h04;
	localparam logic [3:0] POS_IND = 4'h1;
	localparam logic [3:0] POS_ADDR0 = 4'h3;
	localparam logic [3:0] POS_CTX = 4'h7;
	localparam logic [63:0] HIST_RST = 64'h0;
	localparam logic [31:0] TAG_RST = 32'h0;

	typedef struct packed {
		logic [4:0] exc_type;
		logic target_first;
		logic halfword_aligned_set;
		logic with_ctx;
		logic nonsecure_flag;
		logic wide_state_flag;
		logic [1:0] privilege_level_field;
		logic [63:0] ret_addr;
		logic [31:0] virtual_context_tag;
		logic [31:0] context_tag;
	} etp_req_t;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} etp_byte_t;

	// defined exception type codes
	function automatic logic etp_type_legal(input logic [4:0] t);
		logic ok;
		ok = 1'b0;
		unique case (t)
			5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h07: ok = 1'b1;
			5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h0F: ok = 1'b1;
			5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17: ok = 1'b1;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

endpackage

`default_nettype wire

// [core/etp_skid_buf.sv]
// two-entry buffer between the packet sequencer and the byte sink
// assumes producer and consumer on ref_clk_i; outputs come from flops
`default_nettype none

module etp_skid_buf (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// fill side
	input wire logic in_valid_i,
	input var etp_pkg::etp_byte_t in_data_i,
	output logic in_ready_o,
	// drain side
	output logic out_valid_o,
	output etp_pkg::etp_byte_t out_data_o,
	input wire logic out_ready_i
);

	logic spare_valid_r;
	etp_pkg::etp_byte_t spare_r;

	// in_ready is the inverse of the spare_valid_r flop: it drops only when the spare slot holds a word
	assign in_ready_o = !spare_valid_r;

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			out_valid_o <= 1'b0;
			out_data_o <= '0;
			spare_valid_r <= 1'b0;
			spare_r <= '0;
		end else if (ce_i) begin
			if (!out_valid_o || out_ready_i) begin
				if (spare_valid_r) begin
					out_valid_o <= 1'b1;
					out_data_o <= spare_r;
					spare_valid_r <= 1'b0;
				end else begin
					out_valid_o <= in_valid_i;
					out_data_o <= in_data_i;
				end
			end else if (in_valid_i && !spare_valid_r) begin
				spare_valid_r <= 1'b1;
				spare_r <= in_data_i;
			end
		end
	end

endmodule

`default_nettype wire

// [core/etp_tag_track.sv]
// remembers the last identifier value sent and says whether a new one must go out
// assumes commit_i pulses once per packet that carries the field
`default_nettype none

module etp_tag_track (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// control
	input wire logic trace_en_i,
	input wire logic [31:0] value_i,
	input wire logic commit_i,
	// status
	output logic emit_o,
	output logic [31:0] last_o
);

	logic known_r;

	// with tracing on, the first value after reset is always sent; later only on change
	assign emit_o = trace_en_i && (!known_r || (value_i != last_o));

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			known_r <= 1'b0;
			last_o <= etp_pkg::TAG_RST;
		end else if (ce_i && commit_i && emit_o) begin
			known_r <= 1'b1;
			last_o <= value_i;
		end
	end

endmodule

`default_nettype wire

// [core/etp_encoder.sv]
// exception trace packet encoder: takes one exception request and emits its bytes
// assumes requester and byte sink share ref_clk_i; ce_i low freezes everything
`default_nettype none

module etp_encoder (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// configuration
	input wire logic ctag_trace_en_i,
	input wire logic vtag_trace_en_i,
	// request
	input wire logic req_valid_i,
	input var etp_pkg::etp_req_t req_i,
	output logic req_ready_o,
	output logic reject_o,
	// byte stream
	output logic out_valid_o,
	output etp_pkg::etp_byte_t out_o,
	input wire logic out_ready_i,
	// status
	output logic busy_o,
	output logic [63:0] hist0_o
);

	// ************************************************************
	// state
	// ************************************************************
	typedef enum logic {ST_IDLE, ST_SEND} etp_state_t;

	etp_state_t st_r;
	logic [7:0] pkt_r [etp_pkg::PKT_MAX];
	logic [7:0] pkt_nxt [etp_pkg::PKT_MAX];
	logic [3:0] idx_r;
	logic [4:0] len_r;
	logic [4:0] len_nxt;
	logic [63:0] hist_r;
	logic [63:0] hist_nxt;
	logic [63:0] addr_m;
	logic [1:0] ind;
	logic accept;
	logic legal;
	logic push;
	logic last_push;
	logic buf_ready;
	logic cid_emit;
	logic vid_emit;
	logic [31:0] cid_last;
	logic [31:0] vid_last;
	etp_pkg::etp_byte_t push_byte;

	assign accept = ce_i && req_valid_i && req_ready_o;
	assign legal = etp_pkg::etp_type_legal(req_i.exc_type) &&
		(req_i.exc_type != etp_pkg::TYPE_TXN_FAIL); // R9
	assign push = ce_i && (st_r == ST_SEND) && buf_ready;
	assign last_push = push && ({1'b0, idx_r} == (len_r - 5'h01));
	assign push_byte = {pkt_r[idx_r], ({1'b0, idx_r} == (len_r - 5'h01))};
	assign hist0_o = hist_r;

	// ************************************************************
	// identifier trackers
	// ************************************************************
	// a tag goes out only when tracing is on and it differs from the last sent
	etp_tag_track u_vtag (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.trace_en_i(vtag_trace_en_i && req_i.with_ctx), // R18 R19
		.value_i(req_i.virtual_context_tag),
		.commit_i(accept && legal),
		.emit_o(vid_emit),
		.last_o(vid_last)
	);

	etp_tag_track u_ctag (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.trace_en_i(ctag_trace_en_i && req_i.with_ctx), // R16 R17
		.value_i(req_i.context_tag),
		.commit_i(accept && legal),
		.emit_o(cid_emit),
		.last_o(cid_last)
	);

	// ************************************************************
	// packet build
	// ************************************************************
	always_comb begin
		// the set's alignment bits are zero and never travel
		addr_m = req_i.ret_addr;
		if (req_i.halfword_aligned_set) begin
			addr_m[0] = 1'b0; // R3
		end else begin
			addr_m[1:0] = 2'b00; // R2
		end
		// only the two defined indicator codes can be formed
		ind = req_i.target_first ? etp_pkg::IND_TGT_EXC : etp_pkg::IND_EXC_ONLY; // R6 R7 R15
		for (int i = 0; i < etp_pkg::PKT_MAX; i++) begin
			pkt_nxt[i] = 8'h00;
		end
		pkt_nxt[0] = etp_pkg::HDR_BYTE; // R1
		pkt_nxt[1] = {1'b0, ind[1], req_i.exc_type, ind[0]}; // R1 R8
		if (req_i.with_ctx) begin
			pkt_nxt[2] = req_i.halfword_aligned_set ? etp_pkg::FMT_32C_HALF :
				etp_pkg::FMT_32C_WORD;
		end else begin
			pkt_nxt[2] = req_i.halfword_aligned_set ? etp_pkg::FMT_64_HALF :
				etp_pkg::FMT_64_WORD;
		end
		if (req_i.halfword_aligned_set) begin
			pkt_nxt[3] = {1'b0, addr_m[7:1]}; // R11 R13
			pkt_nxt[4] = addr_m[15:8];
		end else begin
			pkt_nxt[3] = {1'b0, addr_m[8:2]}; // R10 R12
			pkt_nxt[4] = {1'b0, addr_m[15:9]};
		end
		pkt_nxt[5] = addr_m[23:16];
		pkt_nxt[6] = addr_m[31:24];
		if (req_i.with_ctx) begin
			// context byte: tag flags, security, width, two zeros, level
			pkt_nxt[7] = {cid_emit, vid_emit, req_i.nonsecure_flag,
				req_i.wide_state_flag, 2'b00, req_i.privilege_level_field}; // R12 R14 R20 R21 R22
			for (int i = 0; i < 4; i++) begin
				if (vid_emit) begin
					pkt_nxt[8 + i] = req_i.virtual_context_tag[8 * i +: 8]; // R14
				end
				if (cid_emit) begin
					pkt_nxt[(vid_emit ? 12 : 8) + i] = req_i.context_tag[8 * i +: 8]; // R14
				end
			end
			len_nxt = etp_pkg::LEN_CTX_BASE + (vid_emit ? etp_pkg::LEN_TAG : 5'h00) +
				(cid_emit ? etp_pkg::LEN_TAG : 5'h00);
		end else begin
			pkt_nxt[7] = addr_m[39:32];
			pkt_nxt[8] = addr_m[47:40];
			pkt_nxt[9] = addr_m[55:48];
			pkt_nxt[10] = addr_m[63:56]; // R10 R11
			len_nxt = etp_pkg::LEN_64;
		end
		// the receiver rebuilds the address by overwriting its entry zero
		if (req_i.with_ctx) begin
			hist_nxt = {hist_r[63:32], addr_m[31:0]}; // R4 R5
		end else begin
			hist_nxt = addr_m; // R4 R5
		end
	end

	// ************************************************************
	// sequencer
	// ************************************************************
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			st_r <= ST_IDLE;
			req_ready_o <= 1'b1;
			busy_o <= 1'b0;
			idx_r <= 4'h0;
			len_r <= 5'h00;
		end else if (ce_i) begin
			unique case (st_r)
				ST_IDLE: begin
					if (accept && legal) begin
						st_r <= ST_SEND;
						req_ready_o <= 1'b0;
						busy_o <= 1'b1;
						idx_r <= 4'h0;
						len_r <= len_nxt;
					end
				end
				ST_SEND: begin
					// a new request waits until the last byte has been pushed into the output buffer
					if (last_push) begin
						st_r <= ST_IDLE; // R23
						req_ready_o <= 1'b1;
						busy_o <= 1'b0;
					end else if (push) begin
						idx_r <= idx_r + 4'h1; // R23
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			for (int i = 0; i < etp_pkg::PKT_MAX; i++) begin
				pkt_r[i] <= 8'h00;
			end
		end else if (accept && legal) begin
			for (int i = 0; i < etp_pkg::PKT_MAX; i++) begin
				pkt_r[i] <= pkt_nxt[i];
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			hist_r <= etp_pkg::HIST_RST;
		end else if (accept && legal) begin
			hist_r <= hist_nxt; // R4
		end
	end

	// illegal types are taken off the request port and dropped, never encoded
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			reject_o <= 1'b0;
		end else if (ce_i) begin
			reject_o <= accept && !legal; // R9
		end
	end

	// ************************************************************
	// output buffer
	// ************************************************************
	// a sink stall fills the buffer and then holds the sequencer on its index
	etp_skid_buf u_buf (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.in_valid_i(st_r == ST_SEND),
		.in_data_i(push_byte),
		.in_ready_o(buf_ready),
		.out_valid_o(out_valid_o),
		.out_data_o(out_o),
		.out_ready_i(out_ready_i)
	);

	// ************************************************************
	// checks
	// ************************************************************
	property p_hdr_first;
		@(posedge ref_clk_i) disable iff (reset_i)
		push && idx_r == 4'h0 |-> push_byte.data == etp_pkg::HDR_BYTE;
	endproperty
	a_hdr_first: assert property (p_hdr_first) else $error("first byte not header"); // R1

	property p_ind_defined;
		@(posedge ref_clk_i) disable iff (reset_i)
		push && idx_r == etp_pkg::POS_IND |->
			!push_byte.data[7] && (push_byte.data[6] != push_byte.data[0]);
	endproperty
	a_ind_defined: assert property (p_ind_defined) else $error("bad indicator byte"); // R6 R7

	property p_no_txn_type;
		@(posedge ref_clk_i) disable iff (reset_i)
		accept && req_i.exc_type == etp_pkg::TYPE_TXN_FAIL |=> reject_o && st_r == ST_IDLE;
	endproperty
	a_no_txn_type: assert property (p_no_txn_type) else $error("reserved type encoded"); // R9

	property p_word_low;
		@(posedge ref_clk_i) disable iff (reset_i)
		accept && legal && !req_i.halfword_aligned_set |=>
			pkt_r[3] == {1'b0, $past(req_i.ret_addr[8:2])} &&
			pkt_r[4][7] == 1'b0;
	endproperty
	a_word_low: assert property (p_word_low) else $error("word address bytes wrong"); // R2 R10

	property p_half_low;
		@(posedge ref_clk_i) disable iff (reset_i)
		accept && legal && req_i.halfword_aligned_set |=>
			pkt_r[3] == {1'b0, $past(req_i.ret_addr[7:1])};
	endproperty
	a_half_low: assert property (p_half_low) else $error("halfword address byte wrong"); // R3 R11

	property p_hist_replace;
		@(posedge ref_clk_i) disable iff (reset_i)
		accept && legal && req_i.with_ctx |=>
			hist_r[63:32] == $past(hist_r[63:32]) &&
			hist_r[31:2] == $past(req_i.ret_addr[31:2]);
	endproperty
	a_hist_replace: assert property (p_hist_replace) else $error("history not replaced"); // R4 R5

	property p_ctx_zero_bits;
		@(posedge ref_clk_i) disable iff (reset_i)
		accept && legal && req_i.with_ctx |=>
			pkt_r[7][3:2] == 2'b00 && pkt_r[7][4] == $past(req_i.wide_state_flag) &&
			pkt_r[7][5] == $past(req_i.nonsecure_flag);
	endproperty
	a_ctx_zero_bits: assert property (p_ctx_zero_bits) else $error("context byte wrong"); // R12 R21 R22

	property p_tag_off;
		@(posedge ref_clk_i) disable iff (reset_i)
		accept && legal && req_i.with_ctx && !ctag_trace_en_i && !vtag_trace_en_i |=>
			len_r == etp_pkg::LEN_CTX_BASE && pkt_r[7][7:6] == 2'b00;
	endproperty
	a_tag_off: assert property (p_tag_off) else $error("disabled tag sent"); // R17 R19

	property p_no_interleave;
		@(posedge ref_clk_i) disable iff (reset_i)
		st_r == ST_SEND && !last_push |=> !req_ready_o && st_r == ST_SEND;
	endproperty
	a_no_interleave: assert property (p_no_interleave) else $error("packet interleaved"); // R23

	property p_len_64;
		@(posedge ref_clk_i) disable iff (reset_i)
		accept && legal && !req_i.with_ctx |=> len_r == etp_pkg::LEN_64;
	endproperty
	a_len_64: assert property (p_len_64) else $error("64-bit form length wrong"); // R10 R11

	// a byte the sink has not taken must stand unchanged, or the stream loses it
	property p_out_hold;
		@(posedge ref_clk_i) disable iff (reset_i)
		out_valid_o && !(ce_i && out_ready_i) |=> out_valid_o && $stable(out_o);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("stalled byte changed"); // R23

	property p_fmt_ctx;
		@(posedge ref_clk_i) disable iff (reset_i)
		accept && legal && req_i.with_ctx |=>
			pkt_r[2] == ($past(req_i.halfword_aligned_set) ? etp_pkg::FMT_32C_HALF :
			etp_pkg::FMT_32C_WORD);
	endproperty
	a_fmt_ctx: assert property (p_fmt_ctx) else $error("context format byte wrong"); // R12 R13

	property p_level;
		@(posedge ref_clk_i) disable iff (reset_i)
		accept && legal && req_i.with_ctx |=>
			pkt_r[etp_pkg::POS_CTX][1:0] == $past(req_i.privilege_level_field);
	endproperty
	a_level: assert property (p_level) else $error("privilege level field wrong"); // R20

	property p_tag_order;
		@(posedge ref_clk_i) disable iff (reset_i)
		accept && legal && req_i.with_ctx && vid_emit && cid_emit |=>
			pkt_r[8] == $past(req_i.virtual_context_tag[7:0]) &&
			pkt_r[12] == $past(req_i.context_tag[7:0]) &&
			len_r == etp_pkg::LEN_CTX_BASE + etp_pkg::LEN_TAG + etp_pkg::LEN_TAG;
	endproperty
	a_tag_order: assert property (p_tag_order) else $error("tag order wrong"); // R14

	property p_addr_high;
		@(posedge ref_clk_i) disable iff (reset_i)
		accept && legal && !req_i.with_ctx |=>
			pkt_r[5] == $past(req_i.ret_addr[23:16]) &&
			pkt_r[10] == $past(req_i.ret_addr[63:56]);
	endproperty
	a_addr_high: assert property (p_addr_high) else $error("upper address bytes wrong"); // R10 R11

	property p_ctag_track;
		@(posedge ref_clk_i) disable iff (reset_i)
		accept && legal && req_i.with_ctx && ctag_trace_en_i |=>
			cid_last == $past(req_i.context_tag);
	endproperty
	a_ctag_track: assert property (p_ctag_track) else $error("context tag not tracked"); // R16

	property p_vtag_track;
		@(posedge ref_clk_i) disable iff (reset_i)
		accept && legal && req_i.with_ctx && vtag_trace_en_i |=>
			vid_last == $past(req_i.virtual_context_tag);
	endproperty
	a_vtag_track: assert property (p_vtag_track) else $error("virtual tag not tracked"); // R18

endmodule

`default_nettype wire

// [tb/etp_sink.sv]
// byte sink model for the exception trace stream, with stall and slow modes
// assumes one clock shared with the encoder; rebuilds the last context fields it saw
`default_nettype none

module etp_sink (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// byte stream
	input wire logic valid_i,
	input var etp_pkg::etp_byte_t byte_i,
	output logic ready_o,
	// test control
	input wire logic stall_i,
	input wire logic slow_i,
	// rebuilt context
	output logic [31:0] last_vtag_o,
	output logic [31:0] last_ctag_o,
	output logic last_ns_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] idx_r;
	logic ctx_r;
	logic [1:0] flags_r;
	logic take;
	assign take = ce_i && valid_i && ready_o;

	// slow mode halves the rate, so the buffer sees a stall every other cycle
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ready_o <= 1'b0;
		end else if (ce_i) begin
			ready_o <= !stall_i && (!slow_i || !ready_o);
		end
	end

	// fields not sent keep the last value received
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			idx_r <= 5'h00;
			ctx_r <= 1'b0;
			flags_r <= 2'h0;
			last_vtag_o <= 32'h00000000;
			last_ctag_o <= 32'h00000000;
			last_ns_o <= 1'b0;
		end else if (take) begin
			idx_r <= byte_i.last ? 5'h00 : idx_r + 5'h01;
			if (idx_r == 5'h02) begin
				ctx_r <= byte_i.data[7:1] == 7'h41;
			end
			if (ctx_r && idx_r == 5'h07) begin
				flags_r <= byte_i.data[7:6];
				last_ns_o <= byte_i.data[5];
			end
			if (ctx_r && idx_r >= 5'h08 && idx_r < 5'h0C && flags_r[0]) begin
				last_vtag_o[{idx_r[1:0], 3'b000} +: 8] <= byte_i.data;
			end else if (ctx_r && idx_r >= 5'h08) begin
				last_ctag_o[{idx_r[1:0], 3'b000} +: 8] <= byte_i.data;
			end
		end
	end
endmodule

`default_nettype wire

// [tb/test_exception_trace_packet_encoder.sv]
// self-checking bench for the exception trace packet encoder
// assumes etp_pkg, the design files and etp_sink are compiled first
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end

module test_exception_trace_packet_encoder;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [4:0] LEGAL [20] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h07, 5'h0A,
		5'h0B, 5'h0C, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17};
	localparam logic [4:0] BAD [4] = '{5'h18, 5'h05, 5'h1F, 5'h09};
	localparam logic [1:0] TEN [5] = '{2'h3, 2'h3, 2'h3, 2'h1, 2'h2};
	localparam logic [31:0] TV [5] = '{32'h0000A001, 32'h0000A001, 32'h0000A001, 32'h00D0000D,
		32'h00D0000D};
	localparam logic [31:0] TC [5] = '{32'hB0000B00, 32'hB0000B00, 32'h00C0C000, 32'h00C0C000,
		32'h0E00000E};
	logic ref_clk_i, reset_i, ce_i, ctag_en, vtag_en, req_valid_i, req_ready_o, reject_o;
	logic out_valid_o, out_ready, busy_o, stall, slow, ce_rand, last_ns, v_seen, c_seen;
	etp_pkg::etp_req_t req_i;
	etp_pkg::etp_byte_t out_o;
	logic [63:0] hist0_o, exp_hist;
	logic [31:0] lfsr, ce_lfsr, v_last, c_last, last_vtag, last_ctag;
	logic [8:0] exp_q [$];
	logic [8:0] exp_b;
	int err_count, checks;

	etp_encoder dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(ce_i),
		.ctag_trace_en_i(ctag_en), .vtag_trace_en_i(vtag_en), .req_valid_i(req_valid_i),
		.req_i(req_i), .req_ready_o(req_ready_o), .reject_o(reject_o), .out_valid_o(out_valid_o),
		.out_o(out_o), .out_ready_i(out_ready), .busy_o(busy_o), .hist0_o(hist0_o));
	etp_sink sink (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(ce_i), .valid_i(out_valid_o),
		.byte_i(out_o), .ready_o(out_ready), .stall_i(stall), .slow_i(slow),
		.last_vtag_o(last_vtag), .last_ctag_o(last_ctag), .last_ns_o(last_ns));

	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction
	function automatic logic [31:0] rnd();
		lfsr = lfsr_next(lfsr);
		return lfsr;
	endfunction
	function automatic etp_pkg::etp_req_t rand_req();
		etp_pkg::etp_req_t r;
		logic [31:0] x;
		x = rnd();
		r.exc_type = LEGAL[x[31:24] % 20];
		{r.target_first, r.halfword_aligned_set, r.with_ctx} = x[2:0];
		{r.nonsecure_flag, r.wide_state_flag, r.privilege_level_field} = x[6:3];
		r.ret_addr = {rnd(), rnd()};
		// a small tag set makes repeats, so omission is exercised
		r.virtual_context_tag = x[7] ? 32'h000000A5 : rnd();
		r.context_tag = x[8] ? 32'h0000005A : rnd();
		return r;
	endfunction
	function automatic void put(input logic [7:0] b);
		exp_q.push_back({b, 1'b0});
	endfunction
	function automatic void expect_pkt(input etp_pkg::etp_req_t r);
		logic [63:0] a;
		logic [1:0] e;
		logic vf, cf;
		a = r.ret_addr;
		a[0] = 1'b0;
		if (!r.halfword_aligned_set) a[1] = 1'b0;
		e = r.target_first ? 2'b10 : 2'b01;
		put(8'h06);
		put({1'b0, e[1], r.exc_type, e[0]});
		put(r.with_ctx ? {7'h41, r.halfword_aligned_set} : (r.halfword_aligned_set ? 8'h9E : 8'h9D));
		if (r.halfword_aligned_set) begin
			put({1'b0, a[7:1]});
			put(a[15:8]);
		end else begin
			put({1'b0, a[8:2]});
			put({1'b0, a[15:9]});
		end
		for (int i = 2; i < (r.with_ctx ? 4 : 8); i++) put(a[8*i +: 8]);
		if (r.with_ctx) begin
			exp_hist[31:0] = a[31:0];
			vf = vtag_en && !(v_seen && v_last == r.virtual_context_tag);
			cf = ctag_en && !(c_seen && c_last == r.context_tag);
			if (vf) {v_seen, v_last} = {1'b1, r.virtual_context_tag};
			if (cf) {c_seen, c_last} = {1'b1, r.context_tag};
			put({cf, vf, r.nonsecure_flag, r.wide_state_flag, 2'b00, r.privilege_level_field});
			for (int i = 0; i < 4; i++) if (vf) put(r.virtual_context_tag[8*i +: 8]);
			for (int i = 0; i < 4; i++) if (cf) put(r.context_tag[8*i +: 8]);
		end else begin
			exp_hist = a;
		end
		exp_q[exp_q.size()-1][0] = 1'b1;
	endfunction

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic hang();
		err_count++;
		$display("wrong value wait expected done seen timeout");
		give_verdict();
	endtask
	task automatic do_reset(input int n);
		reset_i = 1'b1;
		repeat (n) @(negedge ref_clk_i);
		`CHK("idle", 68'h80000000000000000, {req_ready_o, out_valid_o, busy_o, reject_o, hist0_o})
		reset_i = 1'b0;
		exp_q.delete();
		{v_seen, c_seen, exp_hist} = '0;
	endtask
	// enables change only with the request, never under a packet still being queued
	task automatic send(input etp_pkg::etp_req_t r, input logic legal, input logic [1:0] en);
		int n;
		n = 0;
		do begin
			@(negedge ref_clk_i);
			#2;
			n++;
		end while (!(req_ready_o === 1'b1 && ce_i) && n < 2000);
		if (n >= 2000) hang();
		{vtag_en, ctag_en} = en;
		if (legal) expect_pkt(r);
		req_i = r;
		req_valid_i = 1'b1;
		@(negedge ref_clk_i);
		req_valid_i = 1'b0;
		`CHK("hist0", exp_hist, hist0_o)
		`CHK("reject", ~legal, reject_o)
	endtask
	task automatic drain(input string nm);
		int n;
		n = 0;
		while (!(exp_q.size() == 0 && req_ready_o === 1'b1 && busy_o === 1'b0
			&& out_valid_o === 1'b0) && n < 3000) begin
			@(negedge ref_clk_i);
			n++;
		end
		if (n >= 3000) hang();
		$display("test %s done", nm);
	endtask

	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	always @(negedge ref_clk_i) begin
		ce_lfsr <= reset_i ? 32'h78FEF900 : lfsr_next(ce_lfsr);
		ce_i <= ce_rand ? (ce_lfsr[2:0] != 3'h0) : 1'b1;
	end
	always @(posedge ref_clk_i) begin
		if (!reset_i && ce_i && out_valid_o === 1'b1 && out_ready) begin
			if (exp_q.size() == 0) begin
				err_count++;
				$display("wrong value stream expected none seen %h", out_o);
			end else begin
				exp_b = exp_q.pop_front();
				`CHK("byte", exp_b, out_o)
			end
		end
	end

	initial begin
		etp_pkg::etp_req_t r;
		{reset_i, ce_rand, req_valid_i, ctag_en, vtag_en, stall, slow} = 7'h40;
		req_i = '0;
		lfsr = 32'h78FEF900;
		{err_count, checks} = '0;
		do_reset(16);
		// every defined code once, forms cycling with the index, all-ones address for the first four
		for (int i = 0; i < 20; i++) begin
			r = rand_req();
			r.exc_type = LEGAL[i];
			{r.target_first, r.with_ctx, r.halfword_aligned_set} = i[2:0];
			if (i < 4) r.ret_addr = '1;
			send(r, 1'b1, 2'h3);
		end
		drain("codes");
		for (int i = 0; i < 4; i++) begin
			r.exc_type = BAD[i];
			send(r, 1'b0, 2'h3);
		end
		drain("reserved");
		stall = 1'b1;
		r = rand_req();
		{r.with_ctx, r.virtual_context_tag, r.context_tag} = {1'b1, 32'h1234ABCD, 32'h0F0F5555};
		send(r, 1'b1, 2'h3);
		repeat (40) @(negedge ref_clk_i);
		`CHK("held", 12'hA0C, {busy_o, req_ready_o, out_valid_o, out_o})
		stall = 1'b0;
		drain("stall");
		{slow, ce_rand} = 2'h3;
		for (int i = 0; i < 200; i++) begin
			r = rand_req();
			send(r, 1'b1, r.ret_addr[41:40]);
		end
		drain("random");
		{slow, ce_rand} = 2'h0;
		// reset in the middle of a packet; trackers must forget their values
		send(rand_req(), 1'b1, 2'h3);
		do_reset(2);
		for (int i = 0; i < 5; i++) begin
			r = rand_req();
			{r.with_ctx, r.virtual_context_tag, r.context_tag} = {1'b1, TV[i], TC[i]};
			send(r, 1'b1, TEN[i]);
			drain("tags");
			if (TEN[i][1]) `CHK("vtag", TV[i], last_vtag)
			if (TEN[i][0]) `CHK("ctag", TC[i], last_ctag)
			`CHK("nonsecure", r.nonsecure_flag, last_ns)
		end
		give_verdict();
	end
endmodule

`default_nettype wire
